// ===== rtl/pmvs_core.sv
// command handler for alert masks, output format mode, setpoint and upper limit
// assumes a framed transaction port: one request at a time, answered two edges later
`default_nettype none
module pmvs_core (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  txn_valid,
  input  wire pmvs_pkg::pmvs_txn_t   txn,
  output logic                       txn_ready,
  output logic                       resp_valid,
  output pmvs_pkg::pmvs_resp_t       resp,
  input  wire logic                  loop_follower,
  input  wire logic                  output_on,
  input  wire logic [1:0]            scale_sel,
  input  wire logic [11:0]           lower_limit,
  input  wire logic signed [15:0]    trim,
  input  wire logic signed [15:0]    margin_high_step,
  input  wire logic signed [15:0]    margin_low_step,
  input  wire logic                  op_margin_high,
  input  wire logic                  op_margin_low,
  input  wire pmvs_pkg::pmvs_cond_t  status_cond,
  input  wire logic                  clear_faults,
  output pmvs_pkg::pmvs_flags_t      status_flags,
  output logic [15:0]                loop_reference,
  output logic [15:0]                effective_setpoint,
  output logic                       smbalert_out,
  output logic                       smbalert_oe
);
  pmvs_pkg::pmvs_state_t state;
  pmvs_pkg::pmvs_state_t next_state;
  pmvs_pkg::pmvs_txn_t   txn_q;
  pmvs_pkg::pmvs_resp_t  next_resp;
  pmvs_pkg::pmvs_flags_t flag_set;
  logic [7:0]            alert_mask [8];
  logic [7:0]            eff_status [pmvs_pkg::SLOT_COUNT];
  logic [11:0]           setpoint_q;
  logic [11:0]           upper_q;

  logic        take;
  logic        in_check;
  logic        rd;
  logic        cmd_mask;
  logic        cmd_mode;
  logic        cmd_set;
  logic        cmd_max;
  logic        cmd_unknown;
  logic        follower_hit;
  logic [2:0]  slot;
  logic        slot_ok;
  logic        blk_bad;
  logic        set_over;
  logic        nack;
  logic [11:0] set_req;
  logic [11:0] set_ranged;
  logic [11:0] set_final;
  logic [7:0]  mask_rd;
  logic [15:0] rd_data;
  logic [7:0]  rd_count;
  logic        wr_mask;
  logic        wr_set;
  logic        wr_max;
  logic        alert_hit;
  logic [15:0] ref_value;
  logic [15:0] eff_value;
  logic        ref_violation;

  // request decode, held in txn_q during the check cycle
  assign take         = txn_valid & txn_ready;
  assign in_check     = state == pmvs_pkg::S_CHECK;
  assign rd           = txn_q.is_read;
  assign cmd_mask     = txn_q.code == pmvs_pkg::CMD_ALERT_MASK;
  assign cmd_mode     = txn_q.code == pmvs_pkg::CMD_FORMAT_MODE;
  assign cmd_set      = txn_q.code == pmvs_pkg::CMD_SETPOINT;
  assign cmd_max      = txn_q.code == pmvs_pkg::CMD_UPPER_LIMIT;
  assign cmd_unknown  = ~(cmd_mask | cmd_mode | cmd_set | cmd_max);
  assign follower_hit = loop_follower & (cmd_mode | cmd_set | cmd_max);
  assign slot         = pmvs_pkg::mask_slot(txn_q.data[7:0]);
  assign slot_ok      = slot != pmvs_pkg::SLOT_NONE;
  assign blk_bad      = cmd_mask & rd & (txn_q.blk_count != pmvs_pkg::COUNT_BYTE);

  // setpoint checks happen here, before anything reaches the reference path
  assign set_req    = txn_q.data[11:0];
  assign set_over   = cmd_set & ~rd & ~follower_hit
                    & (txn_q.data > {4'h0, pmvs_pkg::SETPOINT_ABS_MAX});
  assign set_ranged = (set_req < pmvs_pkg::range_lo(scale_sel)) ? pmvs_pkg::range_lo(scale_sel)
                    : (set_req > pmvs_pkg::range_hi(scale_sel)) ? pmvs_pkg::range_hi(scale_sel)
                    : set_req;
  // the upper limit is tested first; when the limits cross, values at or below it take the lower limit
  assign set_final  = (set_ranged > upper_q) ? upper_q
                    : (set_ranged < lower_limit) ? lower_limit
                    : set_ranged;

  assign wr_mask = in_check & cmd_mask & ~rd & slot_ok;
  assign wr_set  = in_check & cmd_set & ~rd & ~follower_hit & ~set_over;
  assign wr_max  = in_check & cmd_max & ~rd & ~follower_hit;

  // an unknown status code reads back as an empty mask
  assign mask_rd  = slot_ok ? alert_mask[slot] : 8'h00;
  assign nack     = follower_hit | cmd_unknown | blk_bad | set_over
                  | (cmd_mode & ~rd);
  assign rd_data  = cmd_mask ? {8'h00, mask_rd}
                  : cmd_mode ? {8'h00, pmvs_pkg::FORMAT_MODE_VAL}
                  : cmd_set  ? {4'h0, setpoint_q}
                  : {4'h0, upper_q};
  assign rd_count = (cmd_mask | cmd_mode) ? pmvs_pkg::COUNT_BYTE : pmvs_pkg::COUNT_WORD;

  assign next_resp.ack   = ~nack;
  assign next_resp.count = (rd & ~nack) ? rd_count : 8'h00;
  assign next_resp.data  = (rd & ~nack) ? rd_data : 16'h0000;

  assign flag_set.invalid_command_fault         = in_check & (follower_hit | cmd_unknown | (cmd_mode & ~rd));
  assign flag_set.ivd         = in_check & ((cmd_mask & ~rd & ~slot_ok) | set_over);
  assign flag_set.cml         = flag_set.invalid_command_fault | flag_set.ivd;
  assign flag_set.other       = ref_violation;
  assign flag_set.vout_fault_warn_flag         = ref_violation;
  assign flag_set.vout_maxmin = ref_violation;

  always_comb begin
    case (state)
      pmvs_pkg::S_IDLE:  next_state = take ? pmvs_pkg::S_CHECK : pmvs_pkg::S_IDLE;
      pmvs_pkg::S_CHECK: next_state = pmvs_pkg::S_REPLY;
      pmvs_pkg::S_REPLY: next_state = pmvs_pkg::S_IDLE;
      default:           next_state = pmvs_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state      <= pmvs_pkg::S_IDLE;
      txn_ready  <= 1'b1;
      resp_valid <= 1'b0;
      resp       <= '0;
      txn_q      <= '0;
    end else begin
      state      <= next_state;
      txn_ready  <= next_state == pmvs_pkg::S_IDLE;
      resp_valid <= in_check;
      resp       <= in_check ? next_resp : '0;
      txn_q      <= take ? txn : txn_q;
    end
  end

  // masks only keep bits that have a real source behind them
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 8; i++) begin
      if (rst) begin
        alert_mask[i] <= (i == 0) ? pmvs_pkg::RST_MASK_WORD : pmvs_pkg::RST_MASK_OTHER;
      end else if (wr_mask && slot == 3'(i)) begin
        alert_mask[i] <= txn_q.data[15:8] & pmvs_pkg::slot_impl(3'(i));
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      setpoint_q <= pmvs_pkg::SETPOINT_RST;
      upper_q    <= pmvs_pkg::UPPER_RST;
    end else begin
      setpoint_q <= wr_set ? set_final : setpoint_q;
      upper_q    <= wr_max ? txn_q.data[11:0] : upper_q;
    end
  end

  // a fresh event wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_flags <= '0;
    end else begin
      status_flags <= (clear_faults ? '0 : status_flags) | flag_set;
    end
  end

  pmvs_ref u_ref (
    .setpoint         (setpoint_q),
    .upper_limit      (upper_q),
    .lower_limit      (lower_limit),
    .scale_sel        (scale_sel),
    .trim             (trim),
    .margin_high_step (margin_high_step),
    .margin_low_step  (margin_low_step),
    .op_margin_high   (op_margin_high),
    .op_margin_low    (op_margin_low),
    .output_on        (output_on),
    .ref_value        (ref_value),
    .eff_value        (eff_value),
    .violation        (ref_violation)
  );

  // internal flags join the external conditions at their status bit positions
  assign eff_status[0] = status_cond.word_hi | (8'(status_flags.vout_fault_warn_flag) << pmvs_pkg::BIT_WORD_VFW);
  assign eff_status[1] = status_cond.vout
                       | (8'(status_flags.vout_maxmin) << pmvs_pkg::BIT_VOUT_MAXMIN);
  assign eff_status[2] = status_cond.iout;
  assign eff_status[3] = status_cond.inp;
  assign eff_status[4] = status_cond.temp;
  assign eff_status[5] = status_cond.cml
                       | (8'(status_flags.invalid_command_fault) << pmvs_pkg::BIT_CML_IVC)
                       | (8'(status_flags.ivd) << pmvs_pkg::BIT_CML_IVD);
  assign eff_status[6] = status_cond.mfr;

  always_comb begin
    alert_hit = 1'b0;
    for (int i = 0; i < pmvs_pkg::SLOT_COUNT; i++) begin
      alert_hit = alert_hit
                | (|(eff_status[i] & pmvs_pkg::slot_impl(3'(i)) & ~alert_mask[i]));
    end
  end

  // open-drain alert: only the enable moves, the driven level stays low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      smbalert_out       <= 1'b0;
      smbalert_oe        <= 1'b0;
      loop_reference     <= 16'h0000;
      effective_setpoint <= 16'h0000;
    end else begin
      smbalert_out       <= 1'b0;
      smbalert_oe        <= alert_hit;
      loop_reference     <= ref_value;
      effective_setpoint <= eff_value;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic tk_mask_rd;
  logic tk_mask_wr_bad;
  logic tk_set_wr;
  logic tk_limited;
  assign tk_mask_rd     = take & txn.is_read & (txn.code == pmvs_pkg::CMD_ALERT_MASK);
  assign tk_mask_wr_bad = take & ~txn.is_read & (txn.code == pmvs_pkg::CMD_ALERT_MASK)
                        & (pmvs_pkg::mask_slot(txn.data[7:0]) == pmvs_pkg::SLOT_NONE);
  assign tk_set_wr      = take & ~txn.is_read & (txn.code == pmvs_pkg::CMD_SETPOINT) & ~loop_follower;
  assign tk_limited     = take & loop_follower & ((txn.code == pmvs_pkg::CMD_FORMAT_MODE)
                        | (txn.code == pmvs_pkg::CMD_SETPOINT) | (txn.code == pmvs_pkg::CMD_UPPER_LIMIT));

  property p_reply_timing;
    take |-> !resp_valid ##1 !resp_valid ##1 resp_valid ##1 !resp_valid;
  endproperty
  a_reply_timing: assert property (p_reply_timing) else $error("reply not two edges after request");

  property p_blk_nack;
    tk_mask_rd && txn.blk_count != 8'h01 |-> ##2 resp_valid && !resp.ack;
  endproperty
  a_blk_nack: assert property (p_blk_nack) else $error("bad block count not refused");

  property p_blk_one;
    tk_mask_rd && txn.blk_count == 8'h01 |-> ##2 resp.ack && resp.count == 8'h01;
  endproperty
  a_blk_one: assert property (p_blk_one) else $error("mask read count not one");

  property p_bad_read_zero;
    tk_mask_rd && txn.blk_count == 8'h01
      && pmvs_pkg::mask_slot(txn.data[7:0]) == pmvs_pkg::SLOT_NONE |-> ##2 resp.data == 16'h0000;
  endproperty
  a_bad_read_zero: assert property (p_bad_read_zero) else $error("bad code mask not zero");

  property p_bad_write_flags;
    tk_mask_wr_bad |-> ##2 status_flags.ivd && status_flags.cml ##1 smbalert_oe || alert_mask[5][6];
  endproperty
  a_bad_write_flags: assert property (p_bad_write_flags) else $error("bad mask write not flagged");

  property p_mode_byte;
    take && txn.is_read && txn.code == pmvs_pkg::CMD_FORMAT_MODE && !loop_follower
      |-> ##2 resp.ack && resp.data == 16'h0017 && resp.count == 8'h01;
  endproperty
  a_mode_byte: assert property (p_mode_byte) else $error("format mode byte wrong");

  property p_follower;
    tk_limited |-> ##2 !resp.ack && status_flags.invalid_command_fault && $stable(setpoint_q) && $stable(upper_q);
  endproperty
  a_follower: assert property (p_follower) else $error("follower access not refused");

  property p_over_keep;
    tk_set_wr && txn.data > 16'h0b00
      |-> ##2 !resp.ack && status_flags.ivd && setpoint_q == $past(setpoint_q, 2);
  endproperty
  a_over_keep: assert property (p_over_keep) else $error("oversize setpoint accepted");

  property p_limit_clamp;
    tk_set_wr && txn.data <= 16'h0b00 |-> ##2 setpoint_q <= upper_q && setpoint_q[11:0] != 12'h000;
  endproperty
  a_limit_clamp: assert property (p_limit_clamp) else $error("setpoint beyond upper limit");

  property p_ref_clamp;
    output_on && upper_q <= lower_limit
      |-> ##2 loop_reference == {4'h0, pmvs_pkg::apply_scale($past(upper_q, 2), $past(scale_sel, 2))}
          && status_flags.vout_maxmin && status_flags.other && status_flags.vout_fault_warn_flag;
  endproperty
  a_ref_clamp: assert property (p_ref_clamp) else $error("crossed limits not clamped");

  property p_pgood_reset;
    $past(rst) && !rst |-> alert_mask[0] == 8'h04;
  endproperty
  a_pgood_reset: assert property (disable iff (1'b0) p_pgood_reset) else $error("pgood mask reset");

  c_mask_write: cover property (take && !txn.is_read && txn.code == pmvs_pkg::CMD_ALERT_MASK);
  c_mask_read:  cover property (tk_mask_rd ##2 resp.ack);
  c_set_clamp:  cover property (tk_set_wr ##2 resp.ack);
  c_violation:  cover property (ref_violation ##1 smbalert_oe);
endmodule : pmvs_core
`default_nettype wire

// ===== rtl/pmvs_pkg.sv
// constants, types and helpers for the output-voltage setpoint and alert-mask command block
// assumes a transaction layer in front that has already framed the smbus traffic
`default_nettype none
package pmvs_pkg;
  localparam logic [7:0]  CMD_ALERT_MASK   = 8'h1b;
  localparam logic [7:0]  CMD_FORMAT_MODE  = 8'h20;
  localparam logic [7:0]  CMD_SETPOINT     = 8'h21;
  localparam logic [7:0]  CMD_UPPER_LIMIT  = 8'h24;
  localparam logic [7:0]  ST_WORD          = 8'h79;
  localparam logic [7:0]  ST_VOUT          = 8'h7a;
  localparam logic [7:0]  ST_IOUT          = 8'h7b;
  localparam logic [7:0]  ST_INPUT         = 8'h7c;
  localparam logic [7:0]  ST_TEMP          = 8'h7d;
  localparam logic [7:0]  ST_CML           = 8'h7e;
  localparam logic [7:0]  ST_MFR           = 8'h80;
  localparam logic [2:0]  SLOT_NONE        = 3'h7;
  localparam int          SLOT_COUNT       = 7;
  // implemented mask bits per status code, 19 in total
  localparam logic [7:0]  IMPL_WORD        = 8'h04;
  localparam logic [7:0]  IMPL_VOUT        = 8'hc8;
  localparam logic [7:0]  IMPL_IOUT        = 8'he0;
  localparam logic [7:0]  IMPL_INPUT       = 8'h38;
  localparam logic [7:0]  IMPL_TEMP        = 8'hc0;
  localparam logic [7:0]  IMPL_CML         = 8'hf2;
  localparam logic [7:0]  IMPL_MFR         = 8'h03;
  localparam logic [7:0]  RST_MASK_WORD    = 8'h04;
  localparam logic [7:0]  RST_MASK_OTHER   = 8'h00;
  localparam int          BIT_WORD_VFW     = 7;
  localparam int          BIT_VOUT_MAXMIN  = 3;
  localparam int          BIT_CML_IVC      = 7;
  localparam int          BIT_CML_IVD      = 6;
  localparam logic [2:0]  MODE_LINEAR      = 3'h0;
  localparam logic [4:0]  MODE_EXPONENT    = 5'h17;
  localparam logic [7:0]  FORMAT_MODE_VAL  = {MODE_LINEAR, MODE_EXPONENT};
  localparam logic [11:0] SETPOINT_RST     = 12'h133;
  localparam logic [11:0] UPPER_RST        = 12'h34d;
  localparam logic [11:0] SETPOINT_ABS_MAX = 12'hb00;
  localparam logic [11:0] RANGE1_LO        = 12'h0b3;
  localparam logic [11:0] RANGE1_HI        = 12'h34d;
  localparam logic [11:0] RANGE2_LO        = 12'h166;
  localparam logic [11:0] RANGE2_HI        = 12'h69a;
  localparam logic [11:0] RANGE4_LO        = 12'h2cc;
  localparam logic [11:0] RANGE4_HI        = 12'hb00;
  localparam logic [1:0]  SCALE_ONE        = 2'h0;
  localparam logic [1:0]  SCALE_HALF       = 2'h1;
  localparam logic [1:0]  SCALE_QUARTER    = 2'h2;
  localparam logic [7:0]  COUNT_BYTE       = 8'h01;
  localparam logic [7:0]  COUNT_WORD       = 8'h02;

  typedef struct packed {
    logic        is_read;
    logic [7:0]  code;
    logic [7:0]  blk_count;
    logic [15:0] data;
  } pmvs_txn_t;

  typedef struct packed {
    logic        ack;
    logic [7:0]  count;
    logic [15:0] data;
  } pmvs_resp_t;

  typedef struct packed {
    logic [7:0] word_hi;
    logic [7:0] vout;
    logic [7:0] iout;
    logic [7:0] inp;
    logic [7:0] temp;
    logic [7:0] cml;
    logic [7:0] mfr;
  } pmvs_cond_t;

  typedef struct packed {
    logic other;
    logic cml;
    logic vout_fault_warn_flag;
    logic vout_maxmin;
    logic invalid_command_fault;
    logic ivd;
  } pmvs_flags_t;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_CHECK = 2'b01,
    S_REPLY = 2'b11
  } pmvs_state_t;

  function automatic logic [2:0] mask_slot(input logic [7:0] code);
    case (code)
      ST_WORD:  return 3'h0;
      ST_VOUT:  return 3'h1;
      ST_IOUT:  return 3'h2;
      ST_INPUT: return 3'h3;
      ST_TEMP:  return 3'h4;
      ST_CML:   return 3'h5;
      ST_MFR:   return 3'h6;
      default:  return SLOT_NONE;
    endcase
  endfunction : mask_slot

  function automatic logic [7:0] slot_impl(input logic [2:0] s);
    case (s)
      3'h0:    return IMPL_WORD;
      3'h1:    return IMPL_VOUT;
      3'h2:    return IMPL_IOUT;
      3'h3:    return IMPL_INPUT;
      3'h4:    return IMPL_TEMP;
      3'h5:    return IMPL_CML;
      3'h6:    return IMPL_MFR;
      default: return 8'h00;
    endcase
  endfunction : slot_impl

  function automatic logic [11:0] range_lo(input logic [1:0] sc);
    return (sc == SCALE_HALF) ? RANGE2_LO : (sc == SCALE_QUARTER) ? RANGE4_LO : RANGE1_LO;
  endfunction : range_lo

  function automatic logic [11:0] range_hi(input logic [1:0] sc);
    return (sc == SCALE_HALF) ? RANGE2_HI : (sc == SCALE_QUARTER) ? RANGE4_HI : RANGE1_HI;
  endfunction : range_hi

  function automatic logic [11:0] apply_scale(input logic [11:0] v, input logic [1:0] sc);
    return (sc == SCALE_HALF) ? (v >> 1) : (sc == SCALE_QUARTER) ? (v >> 2) : v;
  endfunction : apply_scale
endpackage : pmvs_pkg
`default_nettype wire

// ===== rtl/pmvs_ref.sv
// reference arithmetic: scaled setpoint plus trim and margins; ref_value clamped by the upper limit only while output_on is set, eff_value never
// assumes all inputs are stable register values of the surrounding command block
`default_nettype none
module pmvs_ref (
  input  wire logic        [11:0] setpoint,
  input  wire logic        [11:0] upper_limit,
  input  wire logic        [11:0] lower_limit,
  input  wire logic        [1:0]  scale_sel,
  input  wire logic signed [15:0] trim,
  input  wire logic signed [15:0] margin_high_step,
  input  wire logic signed [15:0] margin_low_step,
  input  wire logic               op_margin_high,
  input  wire logic               op_margin_low,
  input  wire logic               output_on,
  output logic             [15:0] ref_value,
  output logic             [15:0] eff_value,
  output logic                    violation
);
  logic        [11:0] scaled_set;
  logic        [11:0] scaled_max;
  logic signed [17:0] sum;
  logic signed [17:0] limit_ext;
  logic               over;
  logic               crossed;

  assign scaled_set = pmvs_pkg::apply_scale(setpoint, scale_sel);
  assign scaled_max = pmvs_pkg::apply_scale(upper_limit, scale_sel);
  assign sum        = $signed({6'h00, scaled_set}) + 18'(trim)
                    + (op_margin_high ? 18'(margin_high_step) : 18'sh0)
                    + (op_margin_low  ? 18'(margin_low_step)  : 18'sh0);
  assign limit_ext  = $signed({6'h00, scaled_max});
  assign over       = sum > limit_ext;
  // limits that meet or cross count as a violation while output_on is set; the upper one wins
  assign crossed    = upper_limit <= lower_limit;
  assign violation  = output_on & (over | crossed);
  assign eff_value  = sum[17] ? 16'h0000 : sum[15:0];
  assign ref_value  = violation ? {4'h0, scaled_max} : eff_value;
endmodule : pmvs_ref
`default_nettype wire

// ===== verif/pmvs_host_model.sv
// host model: one framed request at a time
// assumes answers come two edges after the take
`default_nettype none
module pmvs_host_model (
  input  wire logic                 clk_sys,
  input  wire logic                 txn_ready,
  input  wire logic                 resp_valid,
  input  wire pmvs_pkg::pmvs_resp_t resp,
  output logic                      txn_valid,
  output pmvs_pkg::pmvs_txn_t       txn
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    txn_valid = 1'b0;
    txn       = '0;
  end
  // word write: code low, mask high; block read carries its count
  task automatic xfer(input pmvs_pkg::pmvs_txn_t t, output pmvs_pkg::pmvs_resp_t r);
    // ready is only looked at off the edge, so the take edge is known for sure
    @(negedge clk_sys);
    while (txn_ready !== 1'b1) @(negedge clk_sys);
    txn_valid = 1'b1;
    txn       = t;
    @(posedge clk_sys);
    @(negedge clk_sys);
    txn_valid = 1'b0;
    // released lines must not look like a held request
    txn       = ~t;
    @(posedge clk_sys);
    #1;
    r = resp_valid ? resp : 'x;
  endtask : xfer
endmodule : pmvs_host_model
`default_nettype wire

// ===== verif/testbench.sv
// bench for the setpoint and alert-mask command block
// assumes pmvs_host_model frames every request
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk_sys, txn_valid, txn_ready, resp_valid, smbalert_oe;
  logic                  rst = 1'b1, clear_faults = 1'b0, output_on = 1'b0;
  logic                  loop_follower = 1'b0, op_margin_high = 1'b1, op_margin_low = 1'b0;
  logic [1:0]            scale_sel = 2'h0;
  logic [11:0]           lower_limit = 12'h000, v, e;
  logic signed [15:0]    trim = 16'sh0000, margin_high_step = 16'sh0014;
  logic signed [15:0]    margin_low_step = 16'shfff6;
  logic [15:0]           loop_reference;
  logic [7:0]            m, codes [7] = '{8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h80};
  logic [7:0]            impl [7] = '{8'h04, 8'hc8, 8'he0, 8'h38, 8'hc0, 8'hf2, 8'h03};
  pmvs_pkg::pmvs_txn_t   txn;
  pmvs_pkg::pmvs_resp_t  resp, r;
  pmvs_pkg::pmvs_cond_t  status_cond = '0;
  pmvs_pkg::pmvs_flags_t status_flags;
  int                    miscompares = 0, n_checks = 0, cycles = 0;

  pmvs_core DUT (
    .clk_sys(clk_sys), .rst(rst), .txn_valid(txn_valid), .txn(txn), .txn_ready(txn_ready),
    .resp_valid(resp_valid), .resp(resp), .loop_follower(loop_follower), .output_on(output_on),
    .scale_sel(scale_sel), .lower_limit(lower_limit), .trim(trim),
    .margin_high_step(margin_high_step), .margin_low_step(margin_low_step),
    .op_margin_high(op_margin_high), .op_margin_low(op_margin_low), .status_cond(status_cond),
    .clear_faults(clear_faults), .status_flags(status_flags), .loop_reference(loop_reference),
    .effective_setpoint(), .smbalert_out(), .smbalert_oe(smbalert_oe));
  pmvs_host_model host (
    .clk_sys(clk_sys), .txn_ready(txn_ready), .resp_valid(resp_valid), .resp(resp),
    .txn_valid(txn_valid), .txn(txn));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  function automatic logic [15:0] exp_ref(input logic [11:0] sp);
    return 16'($signed({4'h0, sp} >> scale_sel) + trim
               + (op_margin_high ? margin_high_step : 16'sh0000)
               + (op_margin_low ? margin_low_step : 16'sh0000));
  endfunction : exp_ref

  // scale window first, then upper, then lower limit
  function automatic logic [11:0] exp_sp(input logic [11:0] x, input logic [11:0] up);
    logic [11:0] lo, hi;
    lo = 12'd179 << scale_sel;
    hi = (scale_sel == 2'h2) ? 12'd2816 : 12'd845 << scale_sel;
    x = (x < lo) ? lo : (x > hi) ? hi : x;
    x = (x > up) ? up : x;
    return (x < lower_limit) ? lower_limit : x;
  endfunction : exp_sp

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic ack);
    host.xfer('{1'b0, c, 8'h02, d}, r);
    chk({15'h0, r.ack}, {15'h0, ack}, "write ack");
  endtask : wr

  task automatic rd(input logic [7:0] c, input logic [7:0] bc, input logic [7:0] a,
                    input logic ack, input logic [7:0] n, input logic [15:0] exp);
    host.xfer('{1'b1, c, bc, {8'h00, a}}, r);
    chk({15'h0, r.ack}, {15'h0, ack}, "read ack");
    chk({8'h00, r.count}, {8'h00, n}, "read count");
    chk(r.data, exp, "read data");
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic clear;
    @(negedge clk_sys);
    clear_faults = 1'b1;
    @(negedge clk_sys);
    clear_faults = 1'b0;
    settle(2);
  endtask : clear

  task automatic close_out;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  // a hang costs a mismatch rather than a silent stall
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    void'($urandom(32'h9eac760e));
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    rd(8'h20, 8'h01, 8'h00, 1'b1, 8'h01, 16'h0017);
    rd(8'h21, 8'h02, 8'h00, 1'b1, 8'h02, 16'h0133);
    rd(8'h1b, 8'h01, 8'h79, 1'b1, 8'h01, 16'h0004);
    wr(8'h20, 16'h0000, 1'b0);
    rd(8'h20, 8'h01, 8'h00, 1'b1, 8'h01, 16'h0017);
    $display("test reset_and_mode done");
    foreach (codes[i]) begin
      m = 8'($urandom());
      wr(8'h1b, {m, codes[i]}, 1'b1);
      rd(8'h1b, 8'h01, codes[i], 1'b1, 8'h01, {8'h00, m & impl[i]});
    end
    // random masks must not hide the vout and cml alerts checked later
    wr(8'h1b, 16'h007a, 1'b1);
    wr(8'h1b, 16'h007e, 1'b1);
    rd(8'h1b, 8'h02, 8'h7a, 1'b0, 8'h00, 16'h0000);
    rd(8'h1b, 8'h01, 8'h7f, 1'b1, 8'h01, 16'h0000);
    wr(8'h1b, 16'hff7f, 1'b1);
    settle(1);
    chk({13'h0, smbalert_oe, status_flags.cml, status_flags.ivd}, 16'h0007, "bad code");
    clear();
    wr(8'h1b, 16'h407d, 1'b1);
    @(negedge clk_sys);
    status_cond.temp = 8'h40;
    settle(3);
    chk({15'h0, smbalert_oe}, 16'h0000, "masked alert");
    wr(8'h1b, 16'h007d, 1'b1);
    settle(2);
    chk({15'h0, smbalert_oe}, 16'h0001, "unmasked alert");
    @(negedge clk_sys);
    status_cond.temp = 8'h00;
    clear();
    $display("test alert_masks done");
    wr(8'h24, 16'd2816, 1'b1);
    for (int s = 0; s < 3; s++) begin
      repeat (5) begin
        @(negedge clk_sys);
        scale_sel = 2'(s);
        trim = 16'($urandom_range(31)) - 16'sd16;
        op_margin_low = 1'($urandom());
        v = 12'($urandom_range(2816, 100));
        e = exp_sp(v, 12'd2816);
        wr(8'h21, {4'h0, v}, 1'b1);
        rd(8'h21, 8'h02, 8'h00, 1'b1, 8'h02, {4'h0, e});
        chk(loop_reference, exp_ref(e), "reference");
      end
    end
    wr(8'h21, 16'd2817, 1'b0);
    chk({15'h0, status_flags.ivd}, 16'h0001, "invalid data");
    rd(8'h21, 8'h02, 8'h00, 1'b1, 8'h02, {4'h0, e});
    @(negedge clk_sys);
    lower_limit = 12'd1000;
    wr(8'h21, 16'd800, 1'b1);
    rd(8'h21, 8'h02, 8'h00, 1'b1, 8'h02, 16'd1000);
    wr(8'h24, 16'd1200, 1'b1);
    wr(8'h21, 16'd2000, 1'b1);
    rd(8'h21, 8'h02, 8'h00, 1'b1, 8'h02, 16'd1200);
    $display("test setpoint_ranges done");
    @(negedge clk_sys);
    loop_follower = 1'b1;
    wr(8'h21, 16'd900, 1'b0);
    rd(8'h24, 8'h02, 8'h00, 1'b0, 8'h00, 16'h0000);
    chk({15'h0, status_flags.invalid_command_fault}, 16'h0001, "invalid command");
    @(negedge clk_sys);
    loop_follower = 1'b0;
    rd(8'h21, 8'h02, 8'h00, 1'b1, 8'h02, 16'd1200);
    @(negedge clk_sys);
    scale_sel = 2'h0;
    lower_limit = 12'h000;
    trim = 16'sh0000;
    op_margin_low = 1'b0;
    output_on = 1'b1;
    wr(8'h24, 16'd400, 1'b1);
    wr(8'h21, 16'd400, 1'b1);
    settle(2);
    chk(loop_reference, 16'd400, "clamped reference");
    chk({12'h0, status_flags.other, status_flags.vout_fault_warn_flag, status_flags.vout_maxmin, smbalert_oe},
        16'h000f, "limit flags");
    @(negedge clk_sys);
    op_margin_high = 1'b0;
    lower_limit = 12'd500;
    clear();
    settle(2);
    chk(loop_reference, 16'd400, "crossed limits");
    chk({15'h0, status_flags.other}, 16'h0001, "crossed flag");
    $display("test limit_clamp done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
